// ===== verilog/vfd_voice_rx_fifo.sv
// Voice receive FIFO with pattern fill, pointer access, receive DMA intake,
// decoder drain stream, transmit status mirror and transmit DMA length.
// Assumes MAC FIFO, decoder and transmit FIFO logic run on the same clock.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Transmit status bit 3 reads high while a byte enters the transmit FIFO, read-only.
// - Transmit status bit 2 reads high while a byte leaves the transmit FIFO, read-only.
// - An 8-bit read/write transmit DMA length resets to zero and sets bytes per DMA run.
// - Writes to the data port append to the FIFO in order and reads return it in order.
// - With control bit 2 set the pattern byte goes downstream instead of FIFO data.
// - Writing one to control bit 0 overwrites every FIFO location with the pattern.
// - Writing one to control bit 3 starts receive DMA and the bit clears itself.
// - Writing one to control bit 1 zeroes both pointers and clears overflow and underflow.
// - The read pointer is 8-bit read/write, resets to zero, top bit marks wrap.
// - The write pointer is 8-bit read/write, resets to zero, same wrap scheme.
// - Status bit 4 is high while the pattern fill runs and drops when it ends.
// - Receive DMA moves bytes from the MAC receive FIFO into this FIFO for the decoder.
// - Receive status shows push activity and pop activity as read-only bits.
module vfd_voice_rx_fifo
	import vfd_pkg::*;
#(
	parameter int unsigned DEPTH = VFD_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [VFD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic mac_rx_valid,
	input wire logic [7:0] mac_rx_data,
	output logic mac_rx_ready,
	output logic dec_valid,
	output logic [7:0] dec_data,
	input wire logic dec_ready,
	input wire logic tx_push_active,
	input wire logic tx_pop_active,
	output logic [7:0] tx_dma_length
);
	function automatic logic hit(input logic [VFD_ADDR_W-1:0] a, input logic [13:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction : hit

	logic [7:0] mem [DEPTH];
	logic rst_meta_reg, rst_n;
	logic [VFD_PTR_W-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
	logic [VFD_PTR_W-1:0] fill_cnt_reg, fill_cnt_next;
	vfd_fill_state_t fill_state_reg, fill_state_next;
	logic [7:0] pattern_reg, tx_len_reg;
	logic subst_reg, dma_busy_reg, dma_busy_next;
	logic ready_reg, ready_next;
	logic push_act_reg, pop_act_reg, tx_push_reg, tx_pop_reg;
	vfd_evt_t evt_reg, evt_next, mask_reg, evt_set;
	logic [31:0] prdata_reg, rdata_mux;
	logic pready_reg, pslverr_reg, irq_reg;
	logic dec_valid_reg, dec_valid_next;
	logic [7:0] dec_data_reg, dec_data_next;

	wire setup = psel & ~penable;
	wire acc = psel & penable & pready_reg;
	wire wr_acc = acc & pwrite;
	wire rd_acc = acc & ~pwrite;
	wire h_data = hit(paddr, VFD_IDX_DATA);
	wire h_pat = hit(paddr, VFD_IDX_PATTERN);
	wire h_ctl = hit(paddr, VFD_IDX_CTRL);
	wire h_rp = hit(paddr, VFD_IDX_RPTR);
	wire h_wp = hit(paddr, VFD_IDX_WPTR);
	wire h_sts = hit(paddr, VFD_IDX_STATUS);
	wire h_txs = hit(paddr, VFD_IDX_TX_STATUS);
	wire h_txl = hit(paddr, VFD_IDX_TX_LEN);
	wire h_is = hit(paddr, VFD_IDX_IRQ_STATUS);
	wire h_im = hit(paddr, VFD_IDX_IRQ_MASK);
	wire mapped = h_data | h_pat | h_ctl | h_rp | h_wp | h_sts | h_txs | h_txl | h_is | h_im;

	wire fill_busy = (fill_state_reg == VFD_FILL_RUN);
	wire [VFD_PTR_W-1:0] count = wr_ptr_reg - rd_ptr_reg;
	wire empty = (count == '0);
	wire full = (count == VFD_PTR_W'(DEPTH));
	wire [6:0] rd_addr = rd_ptr_reg[6:0];
	wire [6:0] wr_addr = wr_ptr_reg[6:0];

	wire apb_push = wr_acc & h_data & ~fill_busy;
	wire dma_push = mac_rx_valid & ready_reg;
	wire push_req = apb_push | dma_push;
	wire push_ok = push_req & ~full;
	wire [7:0] push_data = apb_push ? pwdata[7:0] : mac_rx_data;
	// data port pop in order; the bus read wins over the decoder
	wire apb_pop = rd_acc & h_data & ~fill_busy;
	wire dec_adv = ~dec_valid_reg | dec_ready;
	wire dec_pop = dec_adv & ~subst_reg & ~fill_busy & ~apb_pop & ~empty;
	wire pop_ok = (apb_pop & ~empty) | dec_pop;

	wire ctl_wr = wr_acc & h_ctl;
	wire ptr_clr = ctl_wr & pwdata[VFD_CTL_CLR];
	wire fill_start = ctl_wr & pwdata[VFD_CTL_FILL] & ~fill_busy;
	wire dma_start = ctl_wr & pwdata[VFD_CTL_DMA];
	wire dma_end = dma_busy_reg & ready_reg & ~mac_rx_valid;
	wire fill_last = fill_busy & (fill_cnt_reg == VFD_PTR_W'(DEPTH - 1));

	// Reset release through two flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	assign rd_ptr_next = ptr_clr ? '0 :
		(wr_acc & h_rp) ? pwdata[7:0] :
		pop_ok ? rd_ptr_reg + VFD_PTR_ONE : rd_ptr_reg;
	assign wr_ptr_next = ptr_clr ? '0 :
		(wr_acc & h_wp) ? pwdata[7:0] :
		push_ok ? wr_ptr_reg + VFD_PTR_ONE : wr_ptr_reg;

	always_comb begin
		fill_state_next = fill_state_reg;
		fill_cnt_next = fill_cnt_reg;
		case (fill_state_reg)
			VFD_FILL_IDLE: begin
				if (fill_start) begin
					fill_state_next = VFD_FILL_RUN;
					fill_cnt_next = '0;
				end
			end
			VFD_FILL_RUN: begin
				fill_cnt_next = fill_cnt_reg + VFD_PTR_ONE;
				if (fill_last) begin
					fill_state_next = VFD_FILL_IDLE;
				end
			end
			default: begin
				fill_state_next = VFD_FILL_IDLE;
			end
		endcase
	end

	assign dma_busy_next = dma_start | (dma_busy_reg & ~dma_end);
	// Ready is registered, so it needs room for one byte beyond the current one
	// and drops ahead of a bus write to the data port to keep one push per cycle.
	assign ready_next = dma_busy_next & ~fill_busy & ~fill_start &
		(count < VFD_PTR_W'(DEPTH - 1)) & ~(setup & pwrite & h_data);

	assign evt_set.overflow = push_req & full;
	assign evt_set.underflow = apb_pop & empty;
	assign evt_set.fill_done = fill_last;
	assign evt_set.dma_done = dma_end;
	// pointer reset also clears the error flags; a new event still wins
	always_comb begin
		evt_next = evt_reg;
		if (wr_acc & h_is) begin
			evt_next = evt_reg & ~vfd_evt_t'(pwdata[3:0]);
		end
		if (ptr_clr) begin
			evt_next.overflow = 1'b0;
			evt_next.underflow = 1'b0;
		end
		evt_next = evt_next | evt_set;
	end

	// pattern substitutes FIFO data toward the decoder
	always_comb begin
		dec_valid_next = dec_valid_reg;
		dec_data_next = dec_data_reg;
		if (dec_adv) begin
			dec_valid_next = subst_reg | dec_pop;
			dec_data_next = subst_reg ? pattern_reg : dec_pop ? mem[rd_addr] : dec_data_reg;
		end
	end

	// Read data is formed in the setup phase so it is stable in the access phase
	always_comb begin
		rdata_mux = VFD_RD_ZERO;
		if (h_data) begin
			rdata_mux[7:0] = mem[rd_addr];
		end else if (h_pat) begin
			rdata_mux[7:0] = pattern_reg;
		end else if (h_ctl) begin
			rdata_mux[VFD_CTL_SUBST] = subst_reg;
		end else if (h_rp) begin
			rdata_mux[7:0] = rd_ptr_reg;
		end else if (h_wp) begin
			rdata_mux[7:0] = wr_ptr_reg;
		end else if (h_sts) begin
			rdata_mux[VFD_STS_FILL] = fill_busy;
			rdata_mux[VFD_STS_PUSH] = push_act_reg;
			rdata_mux[VFD_STS_POP] = pop_act_reg;
		end else if (h_txs) begin
			rdata_mux[VFD_STS_PUSH] = tx_push_reg;
			rdata_mux[VFD_STS_POP] = tx_pop_reg;
		end else if (h_txl) begin
			rdata_mux[7:0] = tx_len_reg;
		end else if (h_is) begin
			rdata_mux[3:0] = evt_reg;
		end else if (h_im) begin
			rdata_mux[3:0] = mask_reg;
		end
	end

	// Storage is not reset; contents are undefined until written or filled
	always_ff @(posedge clock) begin
		if (fill_busy) begin
			mem[fill_cnt_reg[6:0]] <= pattern_reg;
		end else if (push_ok) begin
			mem[wr_addr] <= push_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			fill_state_reg <= VFD_FILL_IDLE;
			fill_cnt_reg <= '0;
			dma_busy_reg <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_reg <= wr_ptr_next;
			fill_state_reg <= fill_state_next;
			fill_cnt_reg <= fill_cnt_next;
			dma_busy_reg <= dma_busy_next;
			ready_reg <= ready_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pattern_reg <= VFD_RST_BYTE;
			subst_reg <= 1'b0;
			tx_len_reg <= VFD_RST_BYTE;
			mask_reg <= vfd_evt_t'(VFD_EVT_ZERO);
		end else if (wr_acc) begin
			if (h_pat) begin
				pattern_reg <= pwdata[7:0];
			end
			if (h_ctl) begin
				subst_reg <= pwdata[VFD_CTL_SUBST];
			end
			if (h_txl) begin
				tx_len_reg <= pwdata[7:0];
			end
			if (h_im) begin
				mask_reg <= vfd_evt_t'(pwdata[3:0]);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			push_act_reg <= 1'b0;
			pop_act_reg <= 1'b0;
			tx_push_reg <= 1'b0;
			tx_pop_reg <= 1'b0;
			evt_reg <= vfd_evt_t'(VFD_EVT_ZERO);
			irq_reg <= 1'b0;
		end else begin
			push_act_reg <= push_ok | fill_busy;
			pop_act_reg <= pop_ok;
			tx_push_reg <= tx_push_active;
			tx_pop_reg <= tx_pop_active;
			evt_reg <= evt_next;
			irq_reg <= |(evt_next & mask_reg);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= VFD_RD_ZERO;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			dec_valid_reg <= 1'b0;
			dec_data_reg <= VFD_RST_BYTE;
		end else begin
			pready_reg <= 1'b1;
			if (setup) begin
				prdata_reg <= rdata_mux;
				pslverr_reg <= ~mapped;
			end
			dec_valid_reg <= dec_valid_next;
			dec_data_reg <= dec_data_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign mac_rx_ready = ready_reg;
	assign dec_valid = dec_valid_reg;
	assign dec_data = dec_data_reg;
	assign tx_dma_length = tx_len_reg;
endmodule : vfd_voice_rx_fifo

`default_nettype wire

// ===== shared/vfd_pkg.sv
// Constants and types for the voice receive FIFO and DMA control block.
// Assumes a 32-bit APB slave with registers at word index times four.
package vfd_pkg;
	localparam int unsigned VFD_DEPTH = 128;
	localparam int unsigned VFD_PTR_W = 8;
	localparam int unsigned VFD_ADDR_W = 16;
	// Register indices; byte address is four times the index
	localparam logic [13:0] VFD_IDX_DATA = 14'h2760;
	localparam logic [13:0] VFD_IDX_PATTERN = 14'h2761;
	localparam logic [13:0] VFD_IDX_CTRL = 14'h2762;
	localparam logic [13:0] VFD_IDX_RPTR = 14'h2763;
	localparam logic [13:0] VFD_IDX_WPTR = 14'h2764;
	localparam logic [13:0] VFD_IDX_STATUS = 14'h276A;
	localparam logic [13:0] VFD_IDX_TX_STATUS = 14'h2770;
	localparam logic [13:0] VFD_IDX_TX_LEN = 14'h2771;
	localparam logic [13:0] VFD_IDX_IRQ_STATUS = 14'h2772;
	localparam logic [13:0] VFD_IDX_IRQ_MASK = 14'h2773;
	// Control bits
	localparam int unsigned VFD_CTL_FILL = 0;
	localparam int unsigned VFD_CTL_CLR = 1;
	localparam int unsigned VFD_CTL_SUBST = 2;
	localparam int unsigned VFD_CTL_DMA = 3;
	// Status bits (receive and transmit status share the layout)
	localparam int unsigned VFD_STS_POP = 2;
	localparam int unsigned VFD_STS_PUSH = 3;
	localparam int unsigned VFD_STS_FILL = 4;
	localparam logic [7:0] VFD_RST_BYTE = 8'h00;
	localparam logic [VFD_PTR_W-1:0] VFD_PTR_ONE = 8'h01;
	localparam logic [31:0] VFD_RD_ZERO = 32'h00000000;
	localparam logic [3:0] VFD_EVT_ZERO = 4'h0;

	typedef struct packed {
		logic dma_done;
		logic fill_done;
		logic underflow;
		logic overflow;
	} vfd_evt_t;

	typedef enum logic [0:0] {
		VFD_FILL_IDLE = 1'b0,
		VFD_FILL_RUN = 1'b1
	} vfd_fill_state_t;
endpackage : vfd_pkg

// ===== test/vfd_voice_rx_fifo_chk.sv
// Port checker for the voice receive FIFO block.
// Assumes one clock and is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module vfd_voice_rx_fifo_chk
	import vfd_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [VFD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mac_rx_valid,
	input wire logic mac_rx_ready,
	input wire logic dec_valid,
	input wire logic [7:0] dec_data,
	input wire logic dec_ready,
	input wire logic [7:0] tx_dma_length
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	wire [13:0] idx = paddr[15:2];
	// Plain access level, so it can be combined with other booleans in antecedents
	wire acc = psel && penable && pready;
	wire wr_acc = psel && penable && pready && pwrite;
	wire mapped = paddr[1:0] == 2'h0 && (idx inside {[VFD_IDX_DATA:VFD_IDX_WPTR],
		VFD_IDX_STATUS, [VFD_IDX_TX_STATUS:VFD_IDX_IRQ_MASK]});
	logic subst_reg;
	logic [7:0] pat_reg;
	// Shadow copies, so the pattern path can be judged from the bus alone
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			subst_reg <= 1'b0;
			pat_reg <= 8'h00;
		end else if (wr_acc && idx == VFD_IDX_CTRL) begin
			subst_reg <= pwdata[VFD_CTL_SUBST];
		end else if (wr_acc && idx == VFD_IDX_PATTERN) begin
			pat_reg <= pwdata[7:0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready low in access phase");
	a_unmapped_error: assert property (s_setup ##1 s_access |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_upper_zero: assert property (s_access |-> prdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	a_length_write: assert property (acc && pwrite && idx == VFD_IDX_TX_LEN
		|=> tx_dma_length == $past(pwdata[7:0]))
		else $error("length output not updated");
	a_ctl_readback: assert property (acc && !pwrite && idx == VFD_IDX_CTRL
		|-> prdata[7:0] == {5'h00, subst_reg, 2'h0})
		else $error("control readback wrong");
	a_tx_reserved: assert property (acc && !pwrite && idx == VFD_IDX_TX_STATUS
		|-> (prdata[7:0] & 8'hF3) == 8'h00)
		else $error("transmit status extra bits");
	a_dec_hold: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_data))
		else $error("decoder byte dropped before taken");
	a_dma_stop: assert property (mac_rx_ready && !mac_rx_valid |=> !mac_rx_ready)
		else $error("receive DMA did not stop");
	a_subst_pattern: assert property ($past(subst_reg && dec_valid && dec_ready)
		&& subst_reg && $stable(pat_reg) && dec_valid |-> dec_data == pat_reg)
		else $error("pattern not sent downstream");
endmodule : vfd_voice_rx_fifo_chk
bind vfd_voice_rx_fifo vfd_voice_rx_fifo_chk chk (.clock, .nrst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .mac_rx_valid, .mac_rx_ready, .dec_valid,
	.dec_data, .dec_ready, .tx_dma_length);
`default_nettype wire

// ===== test/vfd_far_model.sv
// Far side: MAC receive FIFO source and voice decoder sink.
// Assumes the block's clock; the bench queues bytes and may slow the sink.
`timescale 1ns/1ps
`default_nettype none
module vfd_far_model (
	input wire logic clock,
	output logic mac_rx_valid,
	output logic [7:0] mac_rx_data,
	input wire logic mac_rx_ready,
	input wire logic dec_valid,
	input wire logic [7:0] dec_data,
	output logic dec_ready
);
	logic [7:0] src[$];
	logic [7:0] got[$];
	logic slow = 1'b0;
	initial begin
		mac_rx_valid = 1'b0;
		mac_rx_data = 8'h00;
		dec_ready = 1'b1;
	end
	always @(posedge clock) begin
		if (mac_rx_valid && mac_rx_ready) begin
			void'(src.pop_front());
		end
		if (dec_valid && dec_ready) begin
			got.push_back(dec_data);
		end
		mac_rx_valid <= src.size() != 0;
		// Idle data is inverted so a stale byte never looks valid
		mac_rx_data <= src.size() != 0 ? src[0] : ~mac_rx_data;
		dec_ready <= slow ? ~dec_ready : 1'b1;
	end
endmodule : vfd_far_model
`default_nettype wire

// ===== test/vfd_voice_rx_fifo_test.sv
// Self-checking bench for the voice receive FIFO block over APB.
// Assumes the far-side model and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module vfd_voice_rx_fifo_test;
	import vfd_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, mac_rx_valid, mac_rx_ready, dec_valid, dec_ready, e;
	logic [7:0] mac_rx_data, dec_data, tx_dma_length, q;
	logic tx_push_active = 1'b0;
	logic tx_pop_active = 1'b0;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	vfd_voice_rx_fifo uut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .mac_rx_valid, .mac_rx_data, .mac_rx_ready, .dec_valid,
		.dec_data, .dec_ready, .tx_push_active, .tx_pop_active, .tx_dma_length);
	vfd_far_model far (.clock, .mac_rx_valid, .mac_rx_data, .mac_rx_ready, .dec_valid,
		.dec_data, .dec_ready);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Held until pready is sampled high, then released after that edge
	task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic rdc(input string w, input logic [13:0] i, input logic [7:0] m, exp);
		bus(1'b0, i, 8'h00);
		chk(w, q & m, exp);
	endtask : rdc
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		rdc("rptr", VFD_IDX_RPTR, 8'hFF, 8'h00);
		rdc("wptr", VFD_IDX_WPTR, 8'hFF, 8'h00);
		rdc("txlen", VFD_IDX_TX_LEN, 8'hFF, 8'h00);
		bus(1'b1, VFD_IDX_TX_LEN, 8'hA5);
		rdc("txlen", VFD_IDX_TX_LEN, 8'hFF, 8'hA5);
		chk("txlen_out", tx_dma_length, 8'hA5);
		tx_push_active <= 1'b1;
		repeat (3) @(posedge clock);
		rdc("txsts", VFD_IDX_TX_STATUS, 8'hFF, 8'h08);
		tx_push_active <= 1'b0;
		tx_pop_active <= 1'b1;
		repeat (3) @(posedge clock);
		rdc("txsts", VFD_IDX_TX_STATUS, 8'hFF, 8'h04);
		tx_pop_active <= 1'b0;
		bus(1'b1, VFD_IDX_PATTERN, 8'h3C);
		bus(1'b1, VFD_IDX_CTRL, 8'h04);
		rdc("ctrl", VFD_IDX_CTRL, 8'hFF, 8'h04);
		chk("dec_data", dec_data, 8'h3C);
		chk("dec_valid", {7'h00, dec_valid}, 8'h01);
		for (int i = 0; i < 128; i++) begin
			bus(1'b1, VFD_IDX_DATA, 8'(i));
		end
		rdc("wptr_full", VFD_IDX_WPTR, 8'hFF, 8'h80);
		bus(1'b1, VFD_IDX_DATA, 8'hEE);
		rdc("overflow", VFD_IDX_IRQ_STATUS, 8'h01, 8'h01);
		for (int i = 0; i < 3; i++) begin
			rdc("data", VFD_IDX_DATA, 8'hFF, 8'(i));
		end
		rdc("rptr", VFD_IDX_RPTR, 8'hFF, 8'h03);
		bus(1'b1, VFD_IDX_CTRL, 8'h06);
		rdc("rptr_clr", VFD_IDX_RPTR, 8'hFF, 8'h00);
		rdc("wptr_clr", VFD_IDX_WPTR, 8'hFF, 8'h00);
		rdc("flags_clr", VFD_IDX_IRQ_STATUS, 8'h03, 8'h00);
		bus(1'b1, VFD_IDX_IRQ_MASK, 8'h02);
		bus(1'b0, VFD_IDX_DATA, 8'h00);
		rdc("underflow", VFD_IDX_IRQ_STATUS, 8'h03, 8'h02);
		chk("irq", {7'h00, irq}, 8'h01);
		bus(1'b1, VFD_IDX_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge clock);
		chk("irq_clr", {7'h00, irq}, 8'h00);
		rdc("unmapped", 14'h0100, 8'hFF, 8'h00);
		chk("pslverr", {7'h00, e}, 8'h01);
		bus(1'b1, VFD_IDX_CTRL, 8'h05);
		rdc("busy", VFD_IDX_STATUS, 8'h10, 8'h10);
		rdc("push_act", VFD_IDX_STATUS, 8'h08, 8'h08);
		repeat (130) @(posedge clock);
		rdc("idle", VFD_IDX_STATUS, 8'h10, 8'h00);
		rdc("act_idle", VFD_IDX_STATUS, 8'h0C, 8'h00);
		bus(1'b1, VFD_IDX_WPTR, 8'h04);
		for (int i = 0; i < 4; i++) begin
			rdc("fill", VFD_IDX_DATA, 8'hFF, 8'h3C);
		end
		bus(1'b1, VFD_IDX_CTRL, 8'h02);
		repeat (4) @(posedge clock);
		far.got.delete();
		far.slow = 1'b1;
		far.src = '{8'h11, 8'h22, 8'h33};
		bus(1'b1, VFD_IDX_CTRL, 8'h08);
		rdc("ctrl_dma", VFD_IDX_CTRL, 8'h08, 8'h00);
		repeat (20) @(posedge clock);
		chk("count", 8'(far.got.size()), 8'h03);
		for (int i = 0; i < 3; i++) begin
			chk("dma", far.got[i], 8'(8'h11 * (i + 1)));
		end
		give_verdict();
	end
endmodule : vfd_voice_rx_fifo_test
`default_nettype wire
